// file: design/ucp_command_port.sv
// ucp_command_port: command-byte interpreter, register file, descriptor load
// assumes master strobes arrive synchronous to clock; enumeration is abstracted
`timescale 1ns/100ps
`default_nettype none
module ucp_command_port #(
  parameter int NUM_EVENTS = 6,
  parameter int DESCRIPTOR_LOAD_PORT_DEPTH = ucp_pkg::DESCRIPTOR_LOAD_PORT_BYTES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] interface_select_lines,
  input wire logic write_strobe,
  input wire logic [15:0] shared_data_bus_in,
  input wire logic output_enable,
  input wire logic [NUM_EVENTS-1:0] event_sources,
  output logic [15:0] shared_data_bus_out,
  output logic [15:0] shared_data_bus_oe_n,
  output logic ready,
  output logic int_n,
  output logic pullup_connect,
  output logic full_speed_only,
  output logic default_descriptor,
  output logic enumeration_done_event,
  output logic [7:0] interface_config
);
  typedef enum {ST_IDLE, ST_WR_HI, ST_WR_LO, ST_RD_WAIT, ST_RD_HOLD} ucp_cmd_e;
  typedef enum {EN_IDLE, EN_LEN_LO, EN_LEN_HI, EN_BODY, EN_PARSE, EN_ENUM} ucp_enum_e;

  ucp_cmd_e st_r, st_nxt;
  ucp_enum_e en_r, en_nxt;
  ucp_pkg::ucp_cmd_s cmd;
  ucp_pkg::ucp_reg_wr_s wr_r, wr_nxt;
  logic [5:0] addr_r, addr_nxt;
  logic [3:0] hi_r, hi_nxt;
  logic [1:0] busy_r, busy_nxt;
  logic [1:0] lat_r, lat_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] ifcfg_r, ifcfg_nxt;
  logic [7:0] ulo_r, ulo_nxt, uhi_r, uhi_nxt, speed_r, speed_nxt;
  logic [15:0] dlen_r, dlen_nxt, dcnt_r, dcnt_nxt;
  logic [4:0] tmr_r, tmr_nxt;
  logic [NUM_EVENTS-1:0] pend_r, pend_nxt;
  logic pull_r, pull_nxt, done_r, done_nxt, dflt_r, dflt_nxt;
  logic [7:0] descriptor_load_port_mem [DESCRIPTOR_LOAD_PORT_DEPTH];
  logic [8:0] descriptor_load_port_waddr;
  logic descriptor_load_port_we;

  function automatic logic [7:0] read_mux(input logic [5:0] a, input logic [7:0] ic,
      input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] sp);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ucp_pkg::ADDR_IFCFG: v = ic;
      ucp_pkg::ADDR_UNIDX_LO: v = lo;
      ucp_pkg::ADDR_UNIDX_HI: v = hi;
      ucp_pkg::ADDR_UNIDX_VAL: v = ({hi, lo} == ucp_pkg::ADDR_SPEED_OVR) ? sp : 8'h00;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_mux

  assign cmd.wr = write_strobe && (interface_select_lines == ucp_pkg::SEL_COMMAND) && ready;
  assign cmd.data = shared_data_bus_in[7:0];

  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    hi_nxt = hi_r;
    busy_nxt = busy_r;
    lat_nxt = lat_r;
    rdata_nxt = rdata_r;
    wr_nxt = '0;
    if (busy_r != 2'd0) begin
      busy_nxt = busy_r - 2'd1;
    end
    if (cmd.wr) begin
      busy_nxt = 2'(ucp_pkg::BUSY_CYCLES);
    end
    case (st_r)
      ST_RD_WAIT: begin
        if (lat_r != 2'd0) begin
          lat_nxt = lat_r - 2'd1;
        end else begin
          rdata_nxt = read_mux(addr_r, ifcfg_r, ulo_r, uhi_r, speed_r);
          st_nxt = ST_RD_HOLD;
        end
      end
      default: begin
      end
    endcase
    if (cmd.wr) begin
      if (cmd.data[ucp_pkg::POS_IS_ADDR]) begin
        addr_nxt = cmd.data[5:0];
        if (cmd.data[ucp_pkg::POS_IS_READ]) begin
          st_nxt = ST_RD_WAIT;
          lat_nxt = 2'(ucp_pkg::READ_LAT);
        end else begin
          st_nxt = ST_WR_HI;
        end
      end else begin
        case (st_r)
          ST_WR_HI: begin
            hi_nxt = cmd.data[3:0];
            st_nxt = ST_WR_LO;
          end
          ST_WR_LO: begin
            wr_nxt = '{valid: 1'b1, addr: addr_r, data: {hi_r, cmd.data[3:0]}};
            st_nxt = ST_WR_HI;
          end
          default: begin
          end
        endcase
      end
    end
  end

  assign ready = (busy_r == 2'd0);

  always_comb begin
    ifcfg_nxt = ifcfg_r;
    ulo_nxt = ulo_r;
    uhi_nxt = uhi_r;
    speed_nxt = speed_r;
    if (wr_r.valid) begin
      case (wr_r.addr)
        ucp_pkg::ADDR_IFCFG: ifcfg_nxt = wr_r.data;
        ucp_pkg::ADDR_UNIDX_LO: ulo_nxt = wr_r.data;
        ucp_pkg::ADDR_UNIDX_HI: uhi_nxt = wr_r.data;
        ucp_pkg::ADDR_UNIDX_VAL: begin
          if ({uhi_r, ulo_r} == ucp_pkg::ADDR_SPEED_OVR) begin
            speed_nxt = wr_r.data;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    en_nxt = en_r;
    dlen_nxt = dlen_r;
    dcnt_nxt = dcnt_r;
    tmr_nxt = tmr_r;
    pull_nxt = pull_r;
    done_nxt = 1'b0;
    dflt_nxt = dflt_r;
    descriptor_load_port_we = 1'b0;
    descriptor_load_port_waddr = dcnt_r[8:0];
    if (wr_r.valid && wr_r.addr == ucp_pkg::ADDR_DESCRIPTOR_LOAD_PORT && en_r != EN_PARSE
        && en_r != EN_ENUM) begin
      case (en_r)
        EN_IDLE, EN_LEN_LO: begin
          dlen_nxt = {8'h00, wr_r.data};
          en_nxt = EN_LEN_HI;
        end
        EN_LEN_HI: begin
          dlen_nxt = {wr_r.data, dlen_r[7:0]};
          dcnt_nxt = 16'h0000;
          en_nxt = EN_BODY;
        end
        EN_BODY: begin
          descriptor_load_port_we = (dcnt_r < 16'(DESCRIPTOR_LOAD_PORT_DEPTH));
          dcnt_nxt = dcnt_r + 16'h0001;
          if (dcnt_r + 16'h0001 >= dlen_r) begin
            dflt_nxt = (dlen_r == ucp_pkg::DESCRIPTOR_LOAD_PORT_DEFAULT_LEN);
            pull_nxt = 1'b0;
            tmr_nxt = 5'(ucp_pkg::PARSE_CYCLES);
            en_nxt = EN_PARSE;
          end
        end
        default: begin
        end
      endcase
    end else if (wr_r.valid && wr_r.addr != ucp_pkg::ADDR_DESCRIPTOR_LOAD_PORT && en_r != EN_PARSE
        && en_r != EN_ENUM) begin
      en_nxt = EN_IDLE;
    end
    case (en_r)
      EN_PARSE: begin
        if (tmr_r == 5'd0) begin
          pull_nxt = 1'b1;
          tmr_nxt = 5'(ucp_pkg::ENUM_CYCLES);
          en_nxt = EN_ENUM;
        end else begin
          tmr_nxt = tmr_r - 5'd1;
        end
      end
      EN_ENUM: begin
        if (tmr_r == 5'd0) begin
          done_nxt = 1'b1;
          en_nxt = EN_IDLE;
        end else begin
          tmr_nxt = tmr_r - 5'd1;
        end
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    pend_nxt = pend_r | event_sources;
    if (st_r != ST_RD_WAIT && st_r != ST_RD_HOLD) begin
      pend_nxt = event_sources;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      en_r <= EN_IDLE;
      wr_r <= '0;
      addr_r <= 6'h00;
      hi_r <= 4'h0;
      busy_r <= 2'd0;
      lat_r <= 2'd0;
      rdata_r <= 8'h00;
      ifcfg_r <= ucp_pkg::IFCFG_RESET;
      ulo_r <= 8'h00;
      uhi_r <= 8'h00;
      speed_r <= ucp_pkg::SPEED_RESET;
      dlen_r <= 16'h0000;
      dcnt_r <= 16'h0000;
      tmr_r <= 5'd0;
      pend_r <= '0;
      pull_r <= 1'b1;
      done_r <= 1'b0;
      dflt_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      en_r <= en_nxt;
      wr_r <= wr_nxt;
      addr_r <= addr_nxt;
      hi_r <= hi_nxt;
      busy_r <= busy_nxt;
      lat_r <= lat_nxt;
      rdata_r <= rdata_nxt;
      ifcfg_r <= ifcfg_nxt;
      ulo_r <= ulo_nxt;
      uhi_r <= uhi_nxt;
      speed_r <= speed_nxt;
      dlen_r <= dlen_nxt;
      dcnt_r <= dcnt_nxt;
      tmr_r <= tmr_nxt;
      pend_r <= pend_nxt;
      pull_r <= pull_nxt;
      done_r <= done_nxt;
      dflt_r <= dflt_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (descriptor_load_port_we) begin
      descriptor_load_port_mem[descriptor_load_port_waddr] <= wr_r.data;
    end
  end

  // held events show once the read is over
  assign int_n = !((st_r == ST_RD_HOLD) || (st_r != ST_RD_WAIT && (|pend_r)));
  assign shared_data_bus_out = {8'h00, rdata_r};
  // upper byte never driven by command reads
  assign shared_data_bus_oe_n = (output_enable && interface_select_lines ==
      ucp_pkg::SEL_COMMAND) ? 16'hFF00 : 16'hFFFF;
  assign pullup_connect = pull_r;
  assign full_speed_only = (speed_r == ucp_pkg::SPEED_FS_ONLY);
  assign default_descriptor = dflt_r;
  assign enumeration_done_event = done_r;
  assign interface_config = ifcfg_r;

  a_sel_gate: assert property (@(posedge clock) disable iff (!rst_n)
    (write_strobe && ready && interface_select_lines != ucp_pkg::SEL_COMMAND)
      |=> ready && $stable(addr_r))
    else $error("command taken while not selected");
  a_ready_drop: assert property (@(posedge clock) disable iff (!rst_n)
    cmd.wr |=> !ready ##1 !ready ##1 ready)
    else $error("ready did not drop then return");
  a_read_int: assert property (@(posedge clock) disable iff (!rst_n)
    (cmd.wr && cmd.data[7:6] == 2'b11) |-> ##[1:5] !int_n)
    else $error("read interrupt missing");
  a_addr_latch: assert property (@(posedge clock) disable iff (!rst_n)
    (cmd.wr && cmd.data[7]) |=> addr_r == $past(cmd.data[5:0]))
    else $error("address not captured");
  a_write_pair: assert property (@(posedge clock) disable iff (!rst_n)
    (cmd.wr && !cmd.data[7] && st_r == ST_WR_LO) |=> wr_r.valid
      && wr_r.data == {$past(hi_r), $past(cmd.data[3:0])})
    else $error("nibble pair mismatch");
  a_abort_write: assert property (@(posedge clock) disable iff (!rst_n)
    (cmd.wr && cmd.data[7:6] == 2'b10) |=> st_r == ST_WR_HI)
    else $error("partial write not dropped");
  a_rd_wait_int: assert property (@(posedge clock) disable iff (!rst_n)
    (st_r == ST_RD_WAIT) |-> int_n)
    else $error("event leaked during read");
  a_speed_out: assert property (@(posedge clock) disable iff (!rst_n)
    (speed_r == ucp_pkg::SPEED_FS_ONLY) |-> full_speed_only)
    else $error("full speed override lost");
  a_pull_parse: assert property (@(posedge clock) disable iff (!rst_n)
    (en_r == EN_PARSE) |-> !pullup_connect)
    else $error("pull-up connected during parse");
  a_event_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (st_r == ST_RD_HOLD && cmd.wr && cmd.data[7:6] == 2'b10 && (|pend_r)) |=> !int_n)
    else $error("held event not raised after read");
  c_read: cover property (@(posedge clock) st_r == ST_RD_HOLD);
  c_write: cover property (@(posedge clock) wr_r.valid);
  c_enum: cover property (@(posedge clock) enumeration_done_event);
endmodule : ucp_command_port
`default_nettype wire

// file: design/ucp_pkg.sv
// ucp_pkg: constants and carrier types for the command port
// assumes one 125 MHz clock domain and synchronous active-low reset
package ucp_pkg;
  localparam logic [2:0] SEL_COMMAND = 3'b100;
  localparam logic [5:0] ADDR_IFCFG = 6'h01;
  localparam logic [5:0] ADDR_DESCRIPTOR_LOAD_PORT = 6'h30;
  localparam logic [5:0] ADDR_UNIDX_LO = 6'h3A;
  localparam logic [5:0] ADDR_UNIDX_HI = 6'h3B;
  localparam logic [5:0] ADDR_UNIDX_VAL = 6'h3C;
  localparam logic [15:0] ADDR_SPEED_OVR = 16'hE6FB;
  localparam logic [7:0] IFCFG_RESET = 8'h00;
  localparam logic [7:0] SPEED_RESET = 8'h00;
  localparam logic [7:0] SPEED_FS_ONLY = 8'h02;
  localparam int POS_IS_ADDR = 7;
  localparam int POS_IS_READ = 6;
  localparam int DESCRIPTOR_LOAD_PORT_BYTES = 500;
  localparam logic [15:0] DESCRIPTOR_LOAD_PORT_DEFAULT_LEN = 16'h0006;
  localparam int BUSY_CYCLES = 2;
  localparam int READ_LAT = 2;
  localparam int PARSE_CYCLES = 16;
  localparam int ENUM_CYCLES = 16;

  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } ucp_cmd_s;

  typedef struct packed {
    logic valid;
    logic [5:0] addr;
    logic [7:0] data;
  } ucp_reg_wr_s;
endpackage : ucp_pkg

// file: verification/ucp_master_model.sv
// ucp_master_model: external master that writes command bytes one at a time
// assumes the bench owns reset and output enable; bytes wait for ready
`timescale 1ns/100ps
`default_nettype none
module ucp_master_model (
  input wire logic clock,
  input wire logic ready,
  output logic [2:0] interface_select_lines,
  output logic write_strobe,
  output logic [15:0] shared_data_bus_in
);
  initial begin
    interface_select_lines = ucp_pkg::SEL_COMMAND;
    write_strobe = 1'b0;
    shared_data_bus_in = 16'h0000;
  end

  // one byte per call, pairs and series built by caller
  task automatic send(input logic [7:0] b, input logic [2:0] sel, input int gap,
                      output logic ok, output logic dropped);
    int n;
    ok = 1'b0;
    dropped = 1'b0;
    n = 0;
    repeat (gap) @(posedge clock);
    while (n < 64 && !ok) begin
      @(posedge clock);
      ok = (ready === 1'b1);
      n++;
    end
    if (ok) begin
      interface_select_lines <= sel;
      write_strobe <= 1'b1;
      shared_data_bus_in <= {8'($urandom), b};
      @(posedge clock);
      write_strobe <= 1'b0;
      interface_select_lines <= ucp_pkg::SEL_COMMAND;
      shared_data_bus_in <= ~shared_data_bus_in;
      @(posedge clock);
      dropped = (ready === 1'b0);
    end
  endtask : send
endmodule : ucp_master_model
`default_nettype wire

// file: verification/tb_top.sv
// tb_top: self-checking bench for the command port
// assumes the master model strobes bytes; expectations built from constants
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock, rst_n, output_enable, ready, int_n, pullup_connect;
  logic full_speed_only, default_descriptor, enumeration_done_event, write_strobe;
  logic [5:0] event_sources;
  logic [2:0] interface_select_lines;
  logic [15:0] shared_data_bus_in, shared_data_bus_out, shared_data_bus_oe_n;
  logic [7:0] interface_config, v;
  int mismatches, compares, i, n;

  ucp_master_model u_master (.clock(clock), .ready(ready),
    .interface_select_lines(interface_select_lines), .write_strobe(write_strobe),
    .shared_data_bus_in(shared_data_bus_in));

  ucp_command_port u_dut (.clock(clock), .rst_n(rst_n),
    .interface_select_lines(interface_select_lines), .write_strobe(write_strobe),
    .shared_data_bus_in(shared_data_bus_in), .output_enable(output_enable),
    .event_sources(event_sources), .shared_data_bus_out(shared_data_bus_out),
    .shared_data_bus_oe_n(shared_data_bus_oe_n), .ready(ready), .int_n(int_n),
    .pullup_connect(pullup_connect), .full_speed_only(full_speed_only),
    .default_descriptor(default_descriptor),
    .enumeration_done_event(enumeration_done_event),
    .interface_config(interface_config));

  task automatic print_verdict;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask : check8

  task automatic check1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : check1

  task automatic xfer(input logic [7:0] b, input logic [2:0] sel, input logic exp_drop);
    logic ok, dr;
    u_master.send(b, sel, int'($urandom_range(2)), ok, dr);
    if (!ok) begin
      mismatches++;
      print_verdict();
    end
    check1(dr, exp_drop);
  endtask : xfer

  task automatic put_byte(input logic [7:0] d);
    xfer({1'b0, 3'($urandom), d[7:4]}, ucp_pkg::SEL_COMMAND, 1'b1);
    xfer({1'b0, 3'($urandom), d[3:0]}, ucp_pkg::SEL_COMMAND, 1'b1);
    repeat (3) @(posedge clock);
  endtask : put_byte

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    xfer({2'b10, a}, ucp_pkg::SEL_COMMAND, 1'b1);
    put_byte(d);
  endtask : wr_reg

  // flag picker: 0 interrupt, 1 pull-up, 2 enumeration done
  function automatic logic flag_of(input logic [1:0] sel);
    case (sel)
      2'd0: return int_n;
      2'd1: return pullup_connect;
      default: return enumeration_done_event;
    endcase
  endfunction : flag_of

  task automatic wait_flag(input logic [1:0] sel, input logic lvl);
    n = 0;
    while (flag_of(sel) !== lvl && n < 200) begin
      @(posedge clock);
      n++;
    end
    if (flag_of(sel) !== lvl) begin
      mismatches++;
      print_verdict();
    end
    check1(flag_of(sel), lvl);
  endtask : wait_flag

  // read request with events raised while it is outstanding
  task automatic rd_reg(input logic [5:0] a, input logic [7:0] exp);
    output_enable <= 1'b1;
    xfer({2'b11, a}, ucp_pkg::SEL_COMMAND, 1'b1);
    event_sources <= 6'($urandom) | 6'h01;
    repeat (2) @(posedge clock);
    check1(int_n, 1'b1);
    wait_flag(2'd0, 1'b0);
    check8(shared_data_bus_out[7:0], exp);
    check8(shared_data_bus_out[15:8], 8'h00);
    check8(shared_data_bus_oe_n[7:0], 8'h00);
    check8(shared_data_bus_oe_n[15:8], 8'hff);
    check1(int_n, 1'b0);
    output_enable <= 1'b0;
    event_sources <= '0;
  endtask : rd_reg

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    rst_n = 1'b0;
    output_enable = 1'b0;
    event_sources = '0;
    mismatches = 0;
    compares = 0;
    void'($urandom(32'h882f_f7b8));
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'hb0 : 8'($urandom);
      wr_reg(ucp_pkg::ADDR_IFCFG, v);
      check8(interface_config, v);
      rd_reg(ucp_pkg::ADDR_IFCFG, v);
    end
    xfer(8'h81, ucp_pkg::SEL_COMMAND, 1'b1);
    xfer(8'h7a, ucp_pkg::SEL_COMMAND, 1'b1);
    wr_reg(ucp_pkg::ADDR_IFCFG, 8'h3c);
    check8(interface_config, 8'h3c);
    for (i = 0; i < 8; i++) begin
      if (i != 4) begin
        xfer(8'h81, 3'(i), 1'b0);
        xfer(8'h05, 3'(i), 1'b0);
        xfer(8'h05, 3'(i), 1'b0);
      end
    end
    check8(interface_config, 8'h3c);
    wr_reg(ucp_pkg::ADDR_UNIDX_LO, ucp_pkg::ADDR_SPEED_OVR[7:0]);
    wr_reg(ucp_pkg::ADDR_UNIDX_HI, ucp_pkg::ADDR_SPEED_OVR[15:8]);
    wr_reg(ucp_pkg::ADDR_UNIDX_VAL, ucp_pkg::SPEED_FS_ONLY);
    check1(full_speed_only, 1'b1);
    rd_reg(ucp_pkg::ADDR_UNIDX_VAL, ucp_pkg::SPEED_FS_ONLY);
    rd_reg(ucp_pkg::ADDR_UNIDX_LO, ucp_pkg::ADDR_SPEED_OVR[7:0]);
    xfer({2'b10, ucp_pkg::ADDR_DESCRIPTOR_LOAD_PORT}, ucp_pkg::SEL_COMMAND, 1'b1);
    put_byte(ucp_pkg::DESCRIPTOR_LOAD_PORT_DEFAULT_LEN[7:0]);
    put_byte(ucp_pkg::DESCRIPTOR_LOAD_PORT_DEFAULT_LEN[15:8]);
    for (i = 0; i < 6; i++) put_byte(8'($urandom));
    wait_flag(2'd1, 1'b0);
    wait_flag(2'd2, 1'b1);
    check1(pullup_connect, 1'b1);
    check1(default_descriptor, 1'b1);
    xfer(8'h81, ucp_pkg::SEL_COMMAND, 1'b1);
    xfer(8'h07, ucp_pkg::SEL_COMMAND, 1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    xfer(8'h05, ucp_pkg::SEL_COMMAND, 1'b1);
    repeat (3) @(posedge clock);
    check8(interface_config, ucp_pkg::IFCFG_RESET);
    check1(full_speed_only, 1'b0);
    wr_reg(ucp_pkg::ADDR_IFCFG, 8'h12);
    check8(interface_config, 8'h12);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
